/* File: verilog/iap_unit.sv */
// acknowledge, polling, trigger and register logic of the interrupt unit
// assumes core strobes and register accesses on ref_clk; pins are asynchronous
`timescale 1ns/10ps
module iap_unit
	import iap_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [4:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	input  wire logic [2:0]  timer_irq,
	input  wire logic        serial_rx_irq,
	input  wire logic        serial_tx_irq,
	input  wire logic [4:0]  ext_irq_pins,
	output logic             cascade_ack_strobe_0_n,
	output logic             cascade_ack_strobe_0_oe,
	output logic             cascade_ack_strobe_1_n,
	output logic             cascade_ack_strobe_1_oe,
	output logic             core_int_req,
	input  wire logic        core_int_ack,
	output logic             vec_valid,
	output logic      [7:0]  vec_type,
	output logic             cascade_done
);

	// best pending source: lowest level, then lowest index
	function automatic logic [3:0] pick_best(input logic [6:0] pend, input logic [20:0] pri);
		logic [3:0] r;
		logic [2:0] bp;
		r = 4'h0;
		bp = 3'h7;
		for (int i = 0; i < NSRC; i++)
		begin
			if (pend[i] && (!r[3] || pri[i*3 +: 3] < bp))
			begin
				r = {1'b1, 3'(i)};
				bp = pri[i*3 +: 3];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] src_type(input logic [2:0] s, input logic [2:0] ts, input logic [1:0] ss);
		logic [7:0] t;
		t = TYPE_P3;
		unique case (s)
			3'(SRC_TMR): t = ts[0] ? TYPE_T0 : (ts[1] ? TYPE_T1 : TYPE_T2);
			3'(SRC_SER): t = ss[0] ? TYPE_RX : TYPE_TX;
			3'(SRC_P4):  t = TYPE_P4;
			3'(SRC_P0):  t = TYPE_P0;
			3'(SRC_P1):  t = TYPE_P1;
			3'(SRC_P2):  t = TYPE_P2;
			default:     t = TYPE_P3;
		endcase
		return t;
	endfunction

	logic [4:0]  sync1_reg;
	logic [4:0]  sync2_reg;
	logic [20:0] pri_reg;
	logic [6:0]  msk_reg;
	logic [4:0]  lvl_reg;
	logic [1:0]  cas_reg;
	logic [1:0]  nested_self_preempt_enable_reg;
	logic [2:0]  pmask_reg;
	logic [6:0]  isr_reg;
	logic [4:0]  ereq_reg;
	logic [4:0]  arm_reg;
	logic [2:0]  tstat_reg;
	logic [1:0]  sstat_reg;
	logic [2:0]  lat_reg;
	iap_state_t  state_reg;
	logic [3:0]  cnt_reg;
	logic        casc_src_reg;

	logic [4:0]  ext_lvl;
	logic [4:0]  ext_act;
	logic [4:0]  ext_set;
	logic [6:0]  pend;
	logic [6:0]  qual;
	logic [2:0]  isr_min;
	logic [3:0]  win;
	logic [3:0]  isr_top;
	logic [7:0]  win_type;
	logic        poll_rd;
	logic        ack_go;
	logic        casc_ack;
	logic [6:0]  ack_set;
	logic [6:0]  eoi_clr;
	logic [15:0] poll_word;

	function automatic logic wr_at(input logic [4:0] a, input logic [4:0] off, input logic w);
		return w && (a == off);
	endfunction

	// pin synchroniser
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end
		else
		begin
			sync1_reg <= ext_irq_pins;
			sync2_reg <= sync1_reg;
		end
	end

	// ext order: pin4, pin0, pin1, pin2, pin3
	assign ext_lvl = {sync2_reg[3], sync2_reg[2], sync2_reg[1], sync2_reg[0], sync2_reg[4]};
	assign ext_act = ext_lvl & {~cas_reg[1], ~cas_reg[0], 3'b111};
	assign ext_set = ext_act & (lvl_reg | arm_reg);

	assign pend = {ereq_reg, |sstat_reg, |tstat_reg};

	always_comb
	begin
		isr_min = 3'h7;
		for (int i = 0; i < NSRC; i++)
		begin
			if (isr_reg[i] && pri_reg[i*3 +: 3] < isr_min)
			begin
				isr_min = pri_reg[i*3 +: 3];
			end
		end
		for (int i = 0; i < NSRC; i++)
		begin
			qual[i] = pend[i] && !msk_reg[i] && (pri_reg[i*3 +: 3] <= pmask_reg)
				&& (pri_reg[i*3 +: 3] <= isr_min);
		end
		qual[SRC_P0] = qual[SRC_P0] && (!isr_reg[SRC_P0] || nested_self_preempt_enable_reg[0]);
		qual[SRC_P1] = qual[SRC_P1] && (!isr_reg[SRC_P1] || nested_self_preempt_enable_reg[1]);
		for (int i = 0; i < SRC_P0; i++)
		begin
			qual[i] = qual[i] && !isr_reg[i];
		end
		for (int i = SRC_P2; i < NSRC; i++)
		begin
			qual[i] = qual[i] && !isr_reg[i];
		end
	end

	assign win      = pick_best(qual, pri_reg);
	assign isr_top  = pick_best(isr_reg, pri_reg);
	assign win_type = src_type(win[2:0], tstat_reg, sstat_reg);
	assign poll_rd  = reg_rd && (reg_addr == OFF_POLL);
	assign ack_go   = win[3] && (poll_rd || (core_int_ack && state_reg == IAP_IDLE));
	assign casc_ack = win[3] && core_int_ack && !poll_rd && state_reg == IAP_IDLE
		&& ((win[2:0] == 3'(SRC_P0) && cas_reg[0]) || (win[2:0] == 3'(SRC_P1) && cas_reg[1]));
	assign poll_word = win[3] ? {1'b1, 7'h00, win_type} : 16'h0000;

	always_comb
	begin
		ack_set = 7'h00;
		eoi_clr = 7'h00;
		if (ack_go)
		begin
			ack_set[win[2:0]] = 1'b1;
		end
		if (wr_at(reg_addr, OFF_EOI, reg_wr))
		begin
			if (reg_wdata[EOI_NONSPEC_BIT])
			begin
				eoi_clr[isr_top[2:0]] = isr_top[3];
			end
			else
			begin
				for (int i = 0; i < NSRC; i++)
				begin
					if (src_type(3'(i), 3'h1, 2'h1) == reg_wdata[7:0]
						|| (i == SRC_TMR && (reg_wdata[7:0] == TYPE_T1 || reg_wdata[7:0] == TYPE_T2))
						|| (i == SRC_SER && reg_wdata[7:0] == TYPE_TX))
					begin
						eoi_clr[i] = 1'b1;
					end
				end
			end
		end
	end

	// control registers; mask bit has one store for both views
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pri_reg   <= {7{PRI_RESET}};
			msk_reg   <= 7'h7F;
			lvl_reg   <= 5'h00;
			cas_reg   <= 2'h0;
			nested_self_preempt_enable_reg  <= 2'h0;
			pmask_reg <= PRI_RESET;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				OFF_MASK:    msk_reg <= reg_wdata[6:0];
				OFF_PRIMASK: pmask_reg <= reg_wdata[2:0];
				OFF_TCTL, OFF_SCTL, OFF_P4CTL, OFF_P0CTL, OFF_P1CTL, OFF_P2CTL, OFF_P3CTL:
				begin
					pri_reg[(reg_addr[3:1] - 3'h1)*3 +: 3] <= reg_wdata[2:0];
					msk_reg[reg_addr[3:1] - 3'h1] <= reg_wdata[BIT_MSK];
					if (reg_addr >= OFF_P4CTL)
					begin
						lvl_reg[reg_addr[3:1] - 3'h3] <= reg_wdata[BIT_LVL];
					end
					if (reg_addr == OFF_P0CTL || reg_addr == OFF_P1CTL)
					begin
						cas_reg[reg_addr[1]]  <= reg_wdata[BIT_CAS];
						nested_self_preempt_enable_reg[reg_addr[1]] <= reg_wdata[BIT_NESTED_SELF_PREEMPT_ENABLE];
					end
				end
				default: ;
			endcase
		end
	end

	// pending state; a new event wins over a clear in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ereq_reg  <= 5'h00;
			arm_reg   <= 5'h00;
			tstat_reg <= 3'h0;
			sstat_reg <= 2'h0;
			isr_reg   <= 7'h00;
		end
		else
		begin
			for (int j = 0; j < 5; j++)
			begin
				if (lvl_reg[j])
				begin
					ereq_reg[j] <= ext_act[j];
				end
				else if (wr_at(reg_addr, OFF_REQ, reg_wr))
				begin
					ereq_reg[j] <= reg_wdata[j+2] | ext_set[j];
				end
				else
				begin
					ereq_reg[j] <= ext_set[j] | (ereq_reg[j] & ~ack_set[j+2]);
				end
				arm_reg[j] <= !ext_act[j] || (arm_reg[j] && !ext_set[j]);
			end
			if (wr_at(reg_addr, OFF_STATUS, reg_wr))
			begin
				tstat_reg <= reg_wdata[2:0] | timer_irq;
				sstat_reg <= reg_wdata[4:3] | {serial_tx_irq, serial_rx_irq};
			end
			else
			begin
				tstat_reg <= timer_irq | (tstat_reg & ~((ack_set[SRC_TMR] ? 3'h1 : 3'h0)
					<< (tstat_reg[0] ? 2'd0 : (tstat_reg[1] ? 2'd1 : 2'd2))));
				sstat_reg <= {serial_tx_irq, serial_rx_irq} | (sstat_reg & ~((ack_set[SRC_SER] ? 2'h1 : 2'h0)
					<< (sstat_reg[0] ? 1'b0 : 1'b1)));
			end
			if (wr_at(reg_addr, OFF_INSERV, reg_wr))
			begin
				isr_reg <= reg_wdata[6:0] | ack_set;
			end
			else
			begin
				isr_reg <= (isr_reg & ~eoi_clr) | ack_set;
			end
		end
	end

	// latency counter to the core request
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			lat_reg      <= 3'h0;
			core_int_req <= 1'b0;
		end
		else if (!win[3] || ack_go || state_reg != IAP_IDLE)
		begin
			lat_reg      <= 3'h0;
			core_int_req <= 1'b0;
		end
		else
		begin
			lat_reg      <= (lat_reg == LAT_CLKS) ? LAT_CLKS : lat_reg + 3'h1;
			core_int_req <= (lat_reg >= LAT_CLKS - 3'h1);
		end
	end

	// vector hand-over or cascade acknowledge sequence
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_reg    <= IAP_IDLE;
			cnt_reg      <= 4'h0;
			casc_src_reg <= 1'b0;
			vec_valid    <= 1'b0;
			vec_type     <= 8'h00;
			cascade_done <= 1'b0;
		end
		else
		begin
			vec_valid    <= 1'b0;
			cascade_done <= 1'b0;
			unique case (state_reg)
				IAP_IDLE:
				begin
					cnt_reg <= 4'h0;
					if (casc_ack)
					begin
						state_reg    <= IAP_CASCADE_ACK_STROBE_1;
						casc_src_reg <= win[0] ? 1'b0 : 1'b1;
					end
					else if (ack_go && core_int_ack && !poll_rd)
					begin
						vec_valid <= 1'b1;
						vec_type  <= win_type;
					end
				end
				IAP_CASCADE_ACK_STROBE_1:
				begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == INTA_CLKS - 4'h1)
					begin
						state_reg <= IAP_GAP;
						cnt_reg   <= 4'h0;
					end
				end
				IAP_GAP:
				begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == GAP_CLKS - 4'h1)
					begin
						state_reg <= IAP_INTA2;
						cnt_reg   <= 4'h0;
					end
				end
				IAP_INTA2:
				begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == INTA_CLKS - 4'h1)
					begin
						state_reg    <= IAP_IDLE;
						cnt_reg      <= 4'h0;
						cascade_done <= 1'b1;
					end
				end
			endcase
		end
	end

	// strobes follow the acknowledge cycles, registered
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			cascade_ack_strobe_0_n  <= 1'b1;
			cascade_ack_strobe_1_n  <= 1'b1;
			cascade_ack_strobe_0_oe <= 1'b0;
			cascade_ack_strobe_1_oe <= 1'b0;
		end
		else
		begin
			cascade_ack_strobe_0_oe <= cas_reg[0];
			cascade_ack_strobe_1_oe <= cas_reg[1];
			cascade_ack_strobe_0_n  <= !((casc_ack && win[2:0] == 3'(SRC_P0))
				|| ((state_reg == IAP_CASCADE_ACK_STROBE_1 || state_reg == IAP_INTA2) && !casc_src_reg
				&& !(cnt_reg == INTA_CLKS - 4'h1))
				|| (state_reg == IAP_GAP && cnt_reg == GAP_CLKS - 4'h1 && !casc_src_reg));
			cascade_ack_strobe_1_n  <= !((casc_ack && win[2:0] == 3'(SRC_P1))
				|| ((state_reg == IAP_CASCADE_ACK_STROBE_1 || state_reg == IAP_INTA2) && casc_src_reg
				&& !(cnt_reg == INTA_CLKS - 4'h1))
				|| (state_reg == IAP_GAP && cnt_reg == GAP_CLKS - 4'h1 && casc_src_reg));
		end
	end

	// register reads, answer one cycle later
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			reg_rdata  <= 16'h0000;
			if (reg_rd)
			begin
				unique case (reg_addr)
					OFF_POLL, OFF_PEEK: reg_rdata <= poll_word;
					OFF_MASK:    reg_rdata <= {9'h000, msk_reg};
					OFF_PRIMASK: reg_rdata <= {13'h0000, pmask_reg};
					OFF_INSERV:  reg_rdata <= {9'h000, isr_reg};
					OFF_REQ:     reg_rdata <= {9'h000, pend};
					OFF_STATUS:  reg_rdata <= {11'h000, sstat_reg, tstat_reg};
					OFF_TCTL, OFF_SCTL:
						reg_rdata <= {12'h000, msk_reg[reg_addr[3:1] - 3'h1],
							pri_reg[(reg_addr[3:1] - 3'h1)*3 +: 3]};
					OFF_P4CTL, OFF_P2CTL, OFF_P3CTL:
						reg_rdata <= {11'h000, lvl_reg[reg_addr[3:1] - 3'h3], msk_reg[reg_addr[3:1] - 3'h1],
							pri_reg[(reg_addr[3:1] - 3'h1)*3 +: 3]};
					OFF_P0CTL, OFF_P1CTL:
						reg_rdata <= {9'h000, nested_self_preempt_enable_reg[reg_addr[1]], cas_reg[reg_addr[1]],
							lvl_reg[reg_addr[3:1] - 3'h3], msk_reg[reg_addr[3:1] - 3'h1],
							pri_reg[(reg_addr[3:1] - 3'h1)*3 +: 3]};
					default:     reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

endmodule

/* File: verilog/iap_pkg.sv */
// constants for the interrupt acknowledge, poll and trigger unit
// assumes one 125 MHz processor clock and a synchronous active-high reset
package iap_pkg;
	localparam logic [4:0] OFF_EOI     = 5'h02;
	localparam logic [4:0] OFF_POLL    = 5'h04;
	localparam logic [4:0] OFF_PEEK    = 5'h06;
	localparam logic [4:0] OFF_MASK    = 5'h08;
	localparam logic [4:0] OFF_PRIMASK = 5'h0A;
	localparam logic [4:0] OFF_INSERV  = 5'h0C;
	localparam logic [4:0] OFF_REQ     = 5'h0E;
	localparam logic [4:0] OFF_STATUS  = 5'h10;
	localparam logic [4:0] OFF_TCTL    = 5'h12;
	localparam logic [4:0] OFF_SCTL    = 5'h14;
	localparam logic [4:0] OFF_P4CTL   = 5'h16;
	localparam logic [4:0] OFF_P0CTL   = 5'h18;
	localparam logic [4:0] OFF_P1CTL   = 5'h1A;
	localparam logic [4:0] OFF_P2CTL   = 5'h1C;
	localparam logic [4:0] OFF_P3CTL   = 5'h1E;
	// source indices in request, mask and in-service words
	localparam int SRC_TMR = 0;
	localparam int SRC_SER = 1;
	localparam int SRC_P4  = 2;
	localparam int SRC_P0  = 3;
	localparam int SRC_P1  = 4;
	localparam int SRC_P2  = 5;
	localparam int SRC_P3  = 6;
	localparam int NSRC    = 7;
	// control word fields
	localparam int BIT_MSK  = 3;
	localparam int BIT_LVL  = 4;
	localparam int BIT_CAS  = 5;
	localparam int BIT_NESTED_SELF_PREEMPT_ENABLE = 6;
	localparam logic [2:0] PRI_RESET = 3'h7;
	localparam int POLL_VALID_BIT = 15;
	localparam int EOI_NONSPEC_BIT = 15;
	// fixed vector types
	localparam logic [7:0] TYPE_T0 = 8'h08;
	localparam logic [7:0] TYPE_T1 = 8'h12;
	localparam logic [7:0] TYPE_T2 = 8'h13;
	localparam logic [7:0] TYPE_RX = 8'h14;
	localparam logic [7:0] TYPE_TX = 8'h15;
	localparam logic [7:0] TYPE_P0 = 8'h0C;
	localparam logic [7:0] TYPE_P1 = 8'h0D;
	localparam logic [7:0] TYPE_P2 = 8'h0E;
	localparam logic [7:0] TYPE_P3 = 8'h0F;
	localparam logic [7:0] TYPE_P4 = 8'h11;
	// timing in clocks
	localparam logic [2:0] LAT_CLKS   = 3'h5;
	localparam logic [3:0] CASC_CLKS  = 4'hD;
	localparam logic [3:0] INTA_CLKS  = 4'h4;
	localparam logic [3:0] GAP_CLKS   = CASC_CLKS - INTA_CLKS - INTA_CLKS;
	typedef enum logic [1:0] {
		IAP_IDLE  = 2'b00,
		IAP_CASCADE_ACK_STROBE_1 = 2'b01,
		IAP_GAP   = 2'b10,
		IAP_INTA2 = 2'b11
	} iap_state_t;
endpackage

/* File: test/iap_checker.sv */
// port checker for the interrupt acknowledge unit
// assumes the iap_unit ports, bound below by name
`timescale 1ns/10ps
module iap_checker
	import iap_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [4:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic [2:0]  timer_irq,
	input wire logic        cascade_ack_strobe_0_n,
	input wire logic        cascade_ack_strobe_0_oe,
	input wire logic        cascade_ack_strobe_1_n,
	input wire logic        cascade_ack_strobe_1_oe,
	input wire logic        core_int_req,
	input wire logic        core_int_ack,
	input wire logic        vec_valid,
	input wire logic [7:0]  vec_type,
	input wire logic        cascade_done
);
	wire s0 = cascade_ack_strobe_0_n;
	function automatic logic is_type(logic [7:0] t);
		return t inside {TYPE_T0, TYPE_T1, TYPE_T2, TYPE_RX, TYPE_TX, TYPE_P0, TYPE_P1, TYPE_P2, TYPE_P3, TYPE_P4};
	endfunction
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_strobe0_idle: assert property (!cascade_ack_strobe_0_oe |-> s0)
		else $error("strobe 0 low while not driving");
	a_strobe1_idle: assert property (!cascade_ack_strobe_1_oe |-> cascade_ack_strobe_1_n)
		else $error("strobe 1 low while not driving");
	a_casc_shape: assert property ($fell(s0) && $past(s0, 6) |->
		!s0[*4] ##1 s0[*5] ##1 !s0[*4] ##1 (s0 && cascade_done))
		else $error("cascade strobe sequence bad");
	a_casc_novec: assert property ($fell(s0) && $past(s0, 6) |-> !vec_valid[*8])
		else $error("vector given in cascade mode");
	a_vec_cause: assert property (vec_valid |-> $past(core_int_ack))
		else $error("vector without acknowledge");
	a_vec_types: assert property (vec_valid |-> is_type(vec_type))
		else $error("vector type not fixed");
	a_req_drop: assert property (core_int_ack && core_int_req |=> !core_int_req)
		else $error("request kept after acknowledge");
	a_rd_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_idle_data: assert property (!reg_rvalid |-> reg_rdata == 16'h0000)
		else $error("read data outside answer");
	a_poll_type: assert property (reg_rvalid && $past(reg_addr) == OFF_POLL && reg_rdata[15] |-> is_type(reg_rdata[7:0]))
		else $error("poll type not fixed");
	a_latency_min: assert property (timer_irq != 3'h0 && !core_int_req |=> !core_int_req[*4])
		else $error("request too early");
	cover property (cascade_done);
	cover property (vec_valid);
	cover property (reg_rvalid && reg_rdata[15]);
endmodule
bind iap_unit iap_checker chk (.*);

/* File: test/iap_core_model.sv */
// model of the core and of the cascaded controller's acknowledge count
// assumes unit outputs registered on ref_clk
`timescale 1ns/10ps
module iap_core_model (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       ack_en,
	input  wire logic       core_int_req,
	output logic            core_int_ack,
	input  wire logic       vec_valid,
	input  wire logic [7:0] vec_type,
	input  wire logic       strobe_n,
	output logic      [9:0] table_addr,
	output logic      [3:0] casc_acks
);
	logic strobe_d_reg;
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			core_int_ack <= 1'b0;
		else
			core_int_ack <= ack_en && core_int_req && !core_int_ack;
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			table_addr <= 10'h000;
		else if (vec_valid)
			table_addr <= {vec_type, 2'b00};
	end
	always_ff @(posedge ref_clk)
	begin
		strobe_d_reg <= strobe_n;
		if (reset)
			casc_acks <= 4'h0;
		else if (strobe_d_reg && !strobe_n)
			casc_acks <= casc_acks + 4'h1;
	end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the interrupt acknowledge unit
// assumes iap_unit, iap_core_model and the bound checker
`timescale 1ns/10ps
module testbench
	import iap_pkg::*;
;
	logic        ref_clk;
	logic        reset;
	logic [4:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	logic [2:0]  timer_irq;
	logic        serial_rx_irq;
	logic        serial_tx_irq;
	logic [4:0]  pin_drv;
	logic [4:0]  ext_irq_pins;
	logic        s0_n, s0_oe, s1_n, s1_oe;
	logic        core_int_req, core_int_ack, vec_valid, cascade_done, ack_en;
	logic [7:0]  vec_type;
	logic [9:0]  table_addr;
	logic [3:0]  casc_acks;
	int          num_errors = 0;
	int          num_checks = 0;
	int          num_vec = 0;
	// strobes share pins 2 and 3 when driven
	assign ext_irq_pins = {pin_drv[4], s1_oe ? s1_n : pin_drv[3], s0_oe ? s0_n : pin_drv[2], pin_drv[1:0]};
	iap_unit uut (.*, .cascade_ack_strobe_0_n(s0_n), .cascade_ack_strobe_0_oe(s0_oe),
		.cascade_ack_strobe_1_n(s1_n), .cascade_ack_strobe_1_oe(s1_oe));
	iap_core_model core (.*, .strobe_n(s0_n));
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (vec_valid === 1'b1)
			num_vec++;
	task automatic end_of_test;
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [4:0] a, logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [4:0] a, logic [15:0] exp, string what);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		check(what, exp, reg_rdata);
	endtask
	task automatic pin(int i, logic v);
		@(posedge ref_clk);
		pin_drv[i] <= v;
	endtask
	task automatic wait_vec(int n);
		for (int i = 0; i < 80 && num_vec < n; i++)
		begin
			@(posedge ref_clk);
			#1;
		end
		check("vectors", 16'(n), 16'(num_vec));
	endtask
	task automatic t_reset;
		rd(OFF_TCTL, 16'h000F, "timer ctl");
		rd(OFF_P0CTL, 16'h000F, "pin0 ctl");
		rd(OFF_P4CTL, 16'h000F, "pin4 ctl");
		wr(5'h01, 16'h0000);
		rd(OFF_MASK, 16'h007F, "mask");
		rd(OFF_POLL, 16'h0000, "empty poll");
	endtask
	task automatic t_mask;
		wr(OFF_P0CTL, 16'h0000);
		rd(OFF_MASK, 16'h0077, "mask view");
		wr(OFF_MASK, 16'h007F);
		rd(OFF_P0CTL, 16'h0008, "pin0 view");
		wr(OFF_P0CTL, 16'h0000);
		wr(OFF_P1CTL, 16'h0011);
	endtask
	task automatic t_edge;
		pin(0, 1'b1);
		wait_vec(1);
		check("type", 16'h000C, {8'h00, vec_type});
		check("table", 16'h0030, {6'h00, table_addr});
		rd(OFF_INSERV, 16'h0008, "in-service");
		wr(OFF_EOI, 16'h000C);
		repeat (20) @(posedge ref_clk);
		check("no rearm", 16'h0001, 16'(num_vec));
		pin(0, 1'b0);
		repeat (4) @(posedge ref_clk);
		pin(0, 1'b1);
		wait_vec(2);
		pin(0, 1'b0);
		wr(OFF_EOI, 16'h8000);
	endtask
	task automatic t_level;
		pin(1, 1'b1);
		wait_vec(3);
		check("type", 16'h000D, {8'h00, vec_type});
		wr(OFF_EOI, 16'h000D);
		wait_vec(4);
		pin(1, 1'b0);
		repeat (4) @(posedge ref_clk);
		wr(OFF_EOI, 16'h000D);
		repeat (20) @(posedge ref_clk);
		check("vectors", 16'h0004, 16'(num_vec));
	endtask
	task automatic t_poll;
		logic [7:0] types [5] = '{TYPE_T0, TYPE_T1, TYPE_T2, TYPE_RX, TYPE_TX};
		ack_en <= 1'b0;
		wr(OFF_TCTL, 16'h0002);
		wr(OFF_SCTL, 16'h0003);
		@(posedge ref_clk);
		timer_irq <= 3'h7;
		serial_rx_irq <= 1'b1;
		serial_tx_irq <= 1'b1;
		@(posedge ref_clk);
		timer_irq <= 3'h0;
		serial_rx_irq <= 1'b0;
		serial_tx_irq <= 1'b0;
		repeat (8) @(posedge ref_clk);
		for (int i = 0; i < 5; i++)
		begin
			rd(OFF_PEEK, {8'h80, types[i]}, "peek");
			rd(OFF_POLL, {8'h80, types[i]}, "poll");
			rd(OFF_POLL, 16'h0000, "busy poll");
			wr(OFF_EOI, 16'h8000);
			repeat (8) @(posedge ref_clk);
		end
		rd(OFF_POLL, 16'h0000, "empty poll");
	endtask
	task automatic t_casc;
		ack_en <= 1'b1;
		wr(OFF_P0CTL, 16'h0030);
		pin(0, 1'b1);
		#1;
		check("strobe drive", 16'h0001, {15'h0000, s0_oe});
		for (int i = 0; i < 80 && cascade_done !== 1'b1; i++)
			#8;
		check("acks", 16'h0002, {12'h000, casc_acks});
		check("vectors", 16'h0004, 16'(num_vec));
		pin(0, 1'b0);
		repeat (4) @(posedge ref_clk);
		wr(OFF_EOI, 16'h000C);
	endtask
	initial
	begin
		reset = 1'b1;
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
		timer_irq = 3'h0;
		serial_rx_irq = 1'b0;
		serial_tx_irq = 1'b0;
		pin_drv = 5'h00;
		ack_en = 1'b1;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset;
		t_mask;
		t_edge;
		t_level;
		t_poll;
		t_casc;
		end_of_test;
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		end_of_test;
	end
endmodule
